// ### common/crs_pkg.sv
// shared constants and carrier types for the core regulator start-up sequencer
package crs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // start delay before the reference ramp begins, in microseconds
  localparam int unsigned START_DLY_US = 100;
  localparam int unsigned START_DLY_CYC = START_DLY_US * CLK_MHZ;
  // power-good delay after clock-enable, in milliseconds
  localparam int unsigned POWER_GOOD_DLY_MS = 7;
  localparam int unsigned POWER_GOOD_DLY_CYC = POWER_GOOD_DLY_MS * 1000 * CLK_MHZ;
  // consecutive in-window switching cycles before clock-enable
  localparam int unsigned WIN_CYCLES = 13;
  // slew of the target after clock-enable: 10 mV/us
  localparam int unsigned SLEW_MV_PER_US = 10;
  // target voltages in units of 0.1 mV
  localparam int unsigned VOLT_W = 15;
  localparam logic [14:0] BOOT_V = 15'd12000;
  localparam logic [14:0] VMAX_V = 15'd15000;
  localparam logic [14:0] VSTEP_V = 15'd125;
  localparam logic [14:0] WIN_V = 15'd1200;
  // slew step per 1 us tick: 10 mV = 100 units
  localparam logic [14:0] SLEW_STEP_V = 15'(SLEW_MV_PER_US * 10);
  localparam int unsigned US_CYC = CLK_MHZ;
  localparam int unsigned CODE_W = 7;
  localparam logic [6:0] CODE_ZERO_V = 7'h78;
  localparam int unsigned PER_W = 16;
  localparam int unsigned TRIM_W = 8;
  localparam logic [7:0] TRIM_MID = 8'h80;

  typedef enum logic [4:0] {
    CRS_IDLE  = 5'b00001,
    CRS_DELAY = 5'b00010,
    CRS_RAMP  = 5'b00100,
    CRS_SLEW  = 5'b01000,
    CRS_RUN   = 5'b10000
  } crs_state_e;

  // mode request from the system side
  typedef struct packed {
    logic deep_sleep_slow_slew_in;
    logic deep_sleep_n_in;
    logic low_current_n_in;
  } crs_mode_s;

  // per-channel drive toward the analog modulator
  typedef struct packed {
    logic phase1_start;
    logic phase2_start;
    logic phase2_enable;
    logic continuous_conduction;
    logic high_soft_current;
  } crs_drive_s;
endpackage

// ### hw/crs_sequencer.sv
// start-up sequencer, voltage code decode, interleave and balance for a two-phase core regulator
// Operation
// - start only with supply good and enable high
// - ramp to 1.2V boot after 100us
// - force two-phase continuous conduction during start-up
// - low 41uA soft current on boot ramp
// - 13 in-window cycles: clock-enable, high current
// - then slew target to code at 10mV/us
// - power-good 7ms after clock-enable
// - code decodes 1.5V minus 12.5mV per step
// - two channels interleaved 180 degrees apart
// - trim pulse widths until sense averages equal
// - channel2 sense at 5V forces single phase
module crs_sequencer
  import crs_pkg::*;
#(
  parameter int unsigned START_CYC = START_DLY_CYC,
  parameter int unsigned POWER_GOOD_CYC = POWER_GOOD_DLY_CYC
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic supply_por_ok_i,
  input wire logic regulator_on_in_i,
  input wire logic [6:0] voltage_code_i,
  input wire crs_pkg::crs_mode_s mode_i,
  input wire logic channel2_sense_at_rail_i,
  input wire logic [14:0] vout_i,
  input wire logic ramp_done_i,
  input wire logic switch_tick_i,
  input wire logic [15:0] channel_period_i,
  input wire logic channel1_sense_high_i,
  input wire logic channel2_sense_high_i,
  output logic clock_enable_n_o,
  output logic power_good_out_o,
  output logic [14:0] target_v_o,
  output logic low_soft_current_o,
  output crs_pkg::crs_drive_s drive_o,
  output logic [7:0] channel1_trim_o,
  output logic [7:0] channel2_trim_o
);
  import crs_pkg::*;

  // status, code, mode and vout pins pass two flops before use; tick, period and sense-high inputs are used directly
  logic [3:0] sa_r, sb_r;
  logic [6:0] ca_r, cb_r;
  logic [2:0] ma_r, mb_r;
  logic [14:0] va_r, vb_r;
  logic [3:0] sa_nxt;
  always_comb
  begin
    sa_nxt = {supply_por_ok_i, regulator_on_in_i, channel2_sense_at_rail_i, ramp_done_i};
  end
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sa_r <= 4'h0;
      sb_r <= 4'h0;
      ca_r <= 7'h00;
      cb_r <= 7'h00;
      ma_r <= 3'h0;
      mb_r <= 3'h0;
      va_r <= 15'h0000;
      vb_r <= 15'h0000;
    end
    else
    begin
      sa_r <= sa_nxt;
      sb_r <= sa_r;
      ca_r <= voltage_code_i;
      cb_r <= ca_r;
      ma_r <= mode_i;
      mb_r <= ma_r;
      va_r <= vout_i;
      vb_r <= va_r;
    end
  end

  logic por_ok, reg_on, single_phase, ramp_done;
  crs_mode_s mode_s;
  assign por_ok = sb_r[3];
  assign reg_on = sb_r[2];
  assign single_phase = sb_r[1];
  assign ramp_done = sb_r[0];
  assign mode_s = mb_r;

  // code decode; steps past 0x78 floor at zero
  logic [14:0] code_v;
  always_comb
  begin
    if (cb_r >= CODE_ZERO_V)
      code_v = 15'h0000;
    else
      code_v = VMAX_V - 15'(cb_r * VSTEP_V);
  end

  // sequencer
  crs_state_e st_r, st_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [3:0] win_r, win_nxt;
  logic [7:0] us_r, us_nxt;
  logic [14:0] tgt_r, tgt_nxt;
  logic clk_en_n_r, clk_en_n_nxt, pg_r, pg_nxt;
  logic in_win;
  logic [14:0] err;

  always_comb
  begin
    err = (vb_r > BOOT_V) ? vb_r - BOOT_V : BOOT_V - vb_r;
    in_win = err <= WIN_V;
  end

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    win_nxt = win_r;
    us_nxt = us_r;
    tgt_nxt = tgt_r;
    clk_en_n_nxt = clk_en_n_r;
    pg_nxt = pg_r;
    if (!reg_on || !por_ok)
    begin
      st_nxt = CRS_IDLE;
      tmr_nxt = 32'h0;
      win_nxt = 4'h0;
      us_nxt = 8'h00;
      tgt_nxt = 15'h0000;
      clk_en_n_nxt = 1'b1;
      pg_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        CRS_IDLE:
        begin
          st_nxt = CRS_DELAY;
          tmr_nxt = 32'h0;
        end
        CRS_DELAY:
        begin
          if (tmr_r >= START_CYC - 1)
          begin
            st_nxt = CRS_RAMP;
            tgt_nxt = BOOT_V;
            tmr_nxt = 32'h0;
          end
          else
            tmr_nxt = tmr_r + 32'h1;
        end
        CRS_RAMP:
        begin
          // counts only once the soft ramp has reached the boot level
          if (switch_tick_i)
          begin
            if (!in_win || !ramp_done)
              win_nxt = 4'h0;
            else if (win_r == 4'(WIN_CYCLES - 1))
            begin
              st_nxt = CRS_SLEW;
              clk_en_n_nxt = 1'b0;
              win_nxt = 4'h0;
              tmr_nxt = 32'h0;
            end
            else
              win_nxt = win_r + 4'h1;
          end
        end
        default:
        begin
          // slew and run share the power-good timer
          if (us_r == 8'(US_CYC - 1))
          begin
            us_nxt = 8'h00;
            if (tgt_r + SLEW_STEP_V < code_v)
              tgt_nxt = tgt_r + SLEW_STEP_V;
            else if (tgt_r > code_v + SLEW_STEP_V)
              tgt_nxt = tgt_r - SLEW_STEP_V;
            else
              tgt_nxt = code_v;
          end
          else
            us_nxt = us_r + 8'h01;
          if (tgt_r == code_v)
            st_nxt = CRS_RUN;
          if (!pg_r)
          begin
            if (tmr_r >= POWER_GOOD_CYC - 1)
              pg_nxt = 1'b1;
            else
              tmr_nxt = tmr_r + 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_r <= CRS_IDLE;
      tmr_r <= 32'h0;
      win_r <= 4'h0;
      us_r <= 8'h00;
      tgt_r <= 15'h0000;
      clk_en_n_r <= 1'b1;
      pg_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      win_r <= win_nxt;
      us_r <= us_nxt;
      tgt_r <= tgt_nxt;
      clk_en_n_r <= clk_en_n_nxt;
      pg_r <= pg_nxt;
    end
  end

  // interleaved channel timing and mode drive
  logic [15:0] ph_r, ph_nxt;
  logic starting;
  crs_drive_s drv_r, drv_nxt;
  logic low_cur_r, low_cur_nxt;
  always_comb
  begin
    starting = (st_r != CRS_RUN) && (st_r != CRS_SLEW) || clk_en_n_r;
    ph_nxt = (ph_r >= channel_period_i - 16'h1) ? 16'h0 : ph_r + 16'h1;
    drv_nxt.phase1_start = (st_r != CRS_IDLE) && (ph_r == 16'h0);
    drv_nxt.phase2_enable = (st_r != CRS_IDLE) && !single_phase && (starting
      || mode_s.low_current_n_in);
    drv_nxt.phase2_start = drv_nxt.phase2_enable
      && (ph_r == {1'b0, channel_period_i[15:1]});
    drv_nxt.continuous_conduction = starting || !(mode_s.deep_sleep_slow_slew_in
      && !mode_s.deep_sleep_n_in);
    // taken from the next state so both currents swap on the clock-enable edge
    drv_nxt.high_soft_current = !clk_en_n_nxt;
    low_cur_nxt = (st_nxt == CRS_RAMP);
  end

  // balance: step the trims apart while the sense averages differ
  logic [7:0] tr1_r, tr1_nxt, tr2_r, tr2_nxt;
  logic hi1, hi2;
  always_comb
  begin
    hi1 = channel1_sense_high_i;
    hi2 = channel2_sense_high_i;
    tr1_nxt = tr1_r;
    tr2_nxt = tr2_r;
    if (st_r == CRS_IDLE || single_phase)
    begin
      tr1_nxt = TRIM_MID;
      tr2_nxt = TRIM_MID;
    end
    else if (switch_tick_i && hi1 && !hi2 && tr1_r != 8'h00 && tr2_r != 8'hff)
    begin
      tr1_nxt = tr1_r - 8'h01;
      tr2_nxt = tr2_r + 8'h01;
    end
    else if (switch_tick_i && hi2 && !hi1 && tr2_r != 8'h00 && tr1_r != 8'hff)
    begin
      tr1_nxt = tr1_r + 8'h01;
      tr2_nxt = tr2_r - 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ph_r <= 16'h0;
      drv_r <= '0;
      low_cur_r <= 1'b0;
      tr1_r <= TRIM_MID;
      tr2_r <= TRIM_MID;
    end
    else
    begin
      ph_r <= ph_nxt;
      drv_r <= drv_nxt;
      low_cur_r <= low_cur_nxt;
      tr1_r <= tr1_nxt;
      tr2_r <= tr2_nxt;
    end
  end

  assign clock_enable_n_o = clk_en_n_r;
  assign power_good_out_o = pg_r;
  assign target_v_o = tgt_r;
  assign low_soft_current_o = low_cur_r;
  assign drive_o = drv_r;
  assign channel1_trim_o = tr1_r;
  assign channel2_trim_o = tr2_r;
endmodule

// ### sim/crs_sequencer_props.sv
// concurrent checks on the start-up sequencer ports
module crs_sequencer_props
#(
  parameter int unsigned START_CYC = 20,
  parameter int unsigned POWER_GOOD_CYC = 50
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic supply_por_ok_i,
  input wire logic regulator_on_in_i,
  input wire logic channel2_sense_at_rail_i,
  input wire logic clock_enable_n_o,
  input wire logic power_good_out_o,
  input wire logic [14:0] target_v_o,
  input wire logic low_soft_current_o,
  input wire crs_pkg::crs_drive_s drive_o
);
  import crs_pkg::*;
  logic [31:0] low_cnt_r;
  logic [31:0] low_cnt_nxt;
  // cycles since clock-enable went active
  always_comb low_cnt_nxt = clock_enable_n_o ? 32'h0 : low_cnt_r + 32'h1;
  always_ff @(posedge clk_i) low_cnt_r <= low_cnt_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_start_gate: assert property (
    !supply_por_ok_i [*4] |-> clock_enable_n_o && !low_soft_current_o) else $error("ran w/o supply");
  a_boot_target: assert property (
    $rose(low_soft_current_o) |-> target_v_o == BOOT_V) else $error("boot target");
  a_two_phase_boot: assert property (
    low_soft_current_o && !channel2_sense_at_rail_i
      |-> drive_o.phase2_enable && drive_o.continuous_conduction) else $error("start mode");
  a_low_current: assert property (
    low_soft_current_o |-> clock_enable_n_o && !drive_o.high_soft_current) else $error("soft low");
  a_clken_hi_cur: assert property (
    $fell(clock_enable_n_o) |-> drive_o.high_soft_current && !low_soft_current_o)
    else $error("soft high");
  a_pg_delay: assert property (
    power_good_out_o |-> !clock_enable_n_o && low_cnt_r + 1 >= POWER_GOOD_CYC) else $error("pg early");
  a_single_phase: assert property (
    channel2_sense_at_rail_i [*4] |-> !drive_o.phase2_enable) else $error("phase2 on");
  a_abort_idle: assert property (
    !regulator_on_in_i [*5] |-> clock_enable_n_o && !power_good_out_o && !low_soft_current_o)
    else $error("not idle");
  cover property ($fell(clock_enable_n_o));
  cover property ($rose(power_good_out_o));
  cover property ($rose(channel2_sense_at_rail_i));
endmodule

bind crs_sequencer crs_sequencer_props #(.START_CYC(START_CYC), .POWER_GOOD_CYC(POWER_GOOD_CYC))
  u_props (.*);

// ### sim/crs_sys_model.sv
// system side model: enable and voltage code, changed only just after an edge
module crs_sys_model
(
  input wire logic clk_i,
  input wire logic on_req_i,
  input wire logic [6:0] code_req_i,
  output logic regulator_on_in_o,
  output logic [6:0] voltage_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    regulator_on_in_o = 1'b0;
    voltage_code_o = 7'h00;
  end
  always @(posedge clk_i)
  begin
    regulator_on_in_o <= on_req_i;
    voltage_code_o <= code_req_i;
  end
endmodule

// ### sim/tb.sv
// self-checking bench for the core regulator start-up sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  localparam int PG = 50;
  localparam logic [15:0] PER = 16'h0010;
  logic s1 = 1'b1, s2 = 1'b0;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic por = 1'b0, on_req = 1'b1, rail = 1'b0, rdone = 1'b0, tick = 1'b0;
  logic [6:0] code_req = 7'h10;
  logic [14:0] vout = 15'h0;
  // deep sleep with low current requested: start-up must still force two-phase conduction
  crs_mode_s mode = 3'b100;
  logic reg_on, clken_n, pg, lowc;
  logic [6:0] code;
  logic [14:0] tgt;
  crs_drive_s drv;
  logic [7:0] tr1, tr2;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk_i = ~clk_i;
  crs_sys_model u_sys (.clk_i(clk_i), .on_req_i(on_req), .code_req_i(code_req),
    .regulator_on_in_o(reg_on), .voltage_code_o(code));
  crs_sequencer #(.START_CYC(20), .POWER_GOOD_CYC(PG)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
    .supply_por_ok_i(por), .regulator_on_in_i(reg_on), .voltage_code_i(code),
    .mode_i(mode), .channel2_sense_at_rail_i(rail), .vout_i(vout), .ramp_done_i(rdone),
    .switch_tick_i(tick), .channel_period_i(PER), .channel1_sense_high_i(s1),
    .channel2_sense_high_i(s2), .clock_enable_n_o(clken_n), .power_good_out_o(pg),
    .target_v_o(tgt), .low_soft_current_o(lowc), .drive_o(drv),
    .channel1_trim_o(tr1), .channel2_trim_o(tr2));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(logic ok, string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    while (s !== v && lim > 0)
    begin
      cyc(1);
      lim--;
    end
    chk(lim > 0, "wait timed out");
    if (lim == 0)
      tally_and_finish;
  endtask
  // vout is given three edges to pass the input synchronisers
  task automatic pulse(logic [14:0] v);
    vout = v;
    cyc(3);
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(1);
  endtask
  function automatic logic [14:0] exp_v(logic [6:0] c);
    return (c >= 7'h78) ? 15'h0 : 15'(15000 - 125 * int'(c));
  endfunction
  task automatic t_startup;
    int n;
    int p;
    logic [7:0] a, b;
    cyc(40);
    chk(lowc === 1'b0 && clken_n === 1'b1, "started w/o supply");
    por = 1'b1;
    wait_on(lowc, 1'b1, 200);
    chk(tgt === BOOT_V, "boot target");
    chk(drv.phase2_enable === 1'b1, "one phase in start");
    chk(drv.continuous_conduction === 1'b1, "no continuous conduction in start");
    rdone = 1'b1;
    repeat (12) pulse(15'd13199);
    pulse(15'd13300);
    repeat (12) pulse(15'd10801);
    chk(clken_n === 1'b1, "count not restarted");
    pulse(BOOT_V);
    chk(clken_n === 1'b0, "no clock enable");
    chk(drv.high_soft_current === 1'b1 && lowc === 1'b0, "soft current not high");
    n = 0;
    p = 0;
    while (tgt !== exp_v(code_req) && n < 4000)
    begin
      cyc(1);
      n++;
      if (pg === 1'b1 && p == 0)
        p = n;
    end
    chk(p >= PG - 4 && p <= PG + 1, "power good delay");
    chk(n >= 2200 && n <= 2600, "slew rate");
    a = tr1;
    b = tr2;
    repeat (4) pulse(tgt);
    chk(tr1 === a - 8'h04 && tr2 === b + 8'h04, "trim direction");
    s1 = 1'b0;
    s2 = 1'b1;
    repeat (2) pulse(tgt);
    chk(tr1 === a - 8'h02 && tr2 === b + 8'h02, "trim reverse");
    s2 = 1'b0;
    pulse(tgt);
    chk(tr1 === a - 8'h02 && tr2 === b + 8'h02, "trim moved when balanced");
  endtask
  task automatic t_interleave;
    int n;
    mode = 3'b011;
    cyc(4);
    n = 0;
    while (drv.phase1_start !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk(n < 40, "no phase1 start");
    n = 0;
    while (drv.phase2_start !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk(n == int'(PER) / 2, "phase2 not half period after phase1");
    n = 0;
    while (drv.phase1_start !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk(n == int'(PER) / 2, "phase1 not half period after phase2");
  endtask
  task automatic t_codes;
    logic [6:0] tbl [3] = '{7'h01, 7'h60, 7'h7f};
    int n;
    foreach (tbl[i])
    begin
      code_req = tbl[i];
      n = 0;
      while (tgt !== exp_v(code_req) && n < 32000)
      begin
        cyc(1);
        n++;
      end
      chk(tgt === exp_v(code_req), "code decode");
    end
  endtask
  task automatic t_abort_rail;
    on_req = 1'b0;
    wait_on(clken_n, 1'b1, 8);
    chk(pg === 1'b0 && lowc === 1'b0 && tgt === 15'h0000, "abort not idle");
    rail = 1'b1;
    on_req = 1'b1;
    wait_on(lowc, 1'b1, 200);
    chk(drv.phase2_enable === 1'b0, "phase2 with rail");
  endtask
  initial
  begin
    cyc(5);
    nrst_i = 1'b1;
    t_startup;
    t_interleave;
    t_codes;
    t_abort_rail;
    tally_and_finish;
  end
endmodule
